// File: fem_defs.svh
`ifndef FEM_DEFS_SVH
`define FEM_DEFS_SVH

// Command object layout.
`define FEM_CCOB_WORDS   6
`define FEM_IDX_CMD      3'h0
`define FEM_IDX_ADDR     3'h1
`define FEM_IDX_DATA0    3'h2
// Command codes.
`define FEM_CMD_PF_PROG  8'h06
`define FEM_CMD_PF_ERASE 8'h0a
`define FEM_CMD_EE_PROG  8'h11
`define FEM_CMD_EE_ERASE 8'h12
// Global map.
`define FEM_PF_BASE      24'hff_8000
`define FEM_EE_BASE      24'h10_0000
`define FEM_PF_BYTES     32768
`define FEM_EE_BYTES     128
`define FEM_PF_SECT_DW   128
`define FEM_EE_SECT_WD   2
`define FEM_PF_PHRASE_DW 2
`define FEM_EE_BURST_MAX 4
// Algorithm timing.
`define FEM_CLK_NS       10
`define FEM_PROG_NS      200
`define FEM_ERASE_NS     1000
`define FEM_PROG_CYC  ((`FEM_PROG_NS + `FEM_CLK_NS - 1) / `FEM_CLK_NS)
`define FEM_ERASE_CYC ((`FEM_ERASE_NS + `FEM_CLK_NS - 1) / `FEM_CLK_NS)
`endif

// File: fem_pkg.sv
package fem_pkg;
	// Sequencer states.
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_WRITE, ST_VERIFY}
		fem_state_e;
	// Running operation.
	typedef enum logic [2:0] {OP_NONE, OP_PF_PROG, OP_PF_ERASE,
		OP_EE_PROG, OP_EE_ERASE} fem_op_e;
	// Command object write.
	typedef struct packed {
		logic        wr;
		logic [2:0]  idx;
		logic [15:0] data;
	} fem_cmd_wr_s;
	// Array read request; addr is the offset inside the array.
	typedef struct packed {
		logic        req;
		logic        ee;
		logic        word;
		logic [14:0] addr;
	} fem_rd_req_s;
	// Read answer.
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
		logic        sgl;
		logic        dbl;
	} fem_rd_rsp_s;
endpackage

// File: fem_ecc.sv
`timescale 1ns/1ps
module fem_ecc
	import fem_pkg::*;
#(
	parameter int DW = 32,
	parameter int PW = 7
)(
	input  wire logic [DW-1:0] enc_data_i,
	output logic      [PW-1:0] enc_chk_o,
	input  wire logic [DW-1:0] dec_data_i,
	input  wire logic [PW-1:0] dec_chk_i,
	output logic      [DW-1:0] dec_data_o,
	output logic               dec_sgl_o,
	output logic               dec_dbl_o
);
	// The Hamming positions must have room for every data bit.
	if ((1 << (PW - 1)) < DW + PW) begin : g_chk
		$error("fem_ecc: too few check bits");
	end

	// Syndrome over data bits placed at non power of two positions.
	function automatic logic [PW-2:0] fem_syn(input logic [DW-1:0] d);
		logic [PW-2:0] s;
		int            i;
		s = '0;
		i = 0;
		for (int p = 3; p < DW + PW; p++)
			if ((p & (p - 1)) != 0)
			begin
				if (d[i])
					s ^= p[PW-2:0];
				i++;
			end
		return s;
	endfunction

	// Flips the data bit that sits at the syndrome position.
	function automatic logic [DW-1:0] fem_fix(input logic [DW-1:0] d,
		input logic [PW-2:0] s);
		logic [DW-1:0] r;
		int            i;
		r = d;
		i = 0;
		for (int p = 3; p < DW + PW; p++)
			if ((p & (p - 1)) != 0)
			begin
				if (s == p[PW-2:0])
					r[i] = ~d[i];
				i++;
			end
		return r;
	endfunction

	// Encode and decode paths are independent.
	always_comb
	begin
		logic [PW-2:0] es;
		logic [PW-2:0] ds;
		logic          ovr;
		es        = fem_syn(enc_data_i);
		enc_chk_o = {^enc_data_i ^ ^es, es};
		ds        = fem_syn(dec_data_i) ^ dec_chk_i[PW-2:0];
		ovr       = ^dec_data_i ^ ^dec_chk_i;
		// Odd overall parity means one bad bit, which is repaired.
		dec_data_o = ovr ? fem_fix(dec_data_i, ds) : dec_data_i;
		dec_sgl_o  = ovr;
		dec_dbl_o  = !ovr && (ds != '0);
	end
endmodule // fem_ecc

// File: fem_optimer.sv
`timescale 1ns/1ps
module fem_optimer
	import fem_pkg::*;
#(
	parameter int W = 16
)(
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	input  wire logic         start_i,
	input  wire logic [W-1:0] cycles_i,
	output logic              done_o
);
	if (W < 2) begin : g_chk
		$error("fem_optimer: width too small");
	end

	// Countdown state.
	typedef struct packed {
		logic         busy;
		logic [W-1:0] cnt;
		logic         done;
	} fem_tmr_s;

	fem_tmr_s st_ff;   // Registered state.
	fem_tmr_s nxt_st;  // Next state.

	// Counts the pulse time down and flags its end for one cycle.
	always_comb
	begin
		nxt_st      = st_ff;
		nxt_st.done = 1'b0;
		if (start_i)
		begin
			nxt_st.busy = 1'b1;
			nxt_st.cnt  = cycles_i;
		end
		else if (st_ff.busy)
		begin
			if (st_ff.cnt <= W'(1))
			begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
			end
			else
				nxt_st.cnt = st_ff.cnt - W'(1);
		end
	end

	// Synchronous reset.
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign done_o = st_ff.done;
endmodule // fem_optimer

// File: fem_ctrl.sv
`timescale 1ns/1ps
`include "fem_defs.svh"
module fem_ctrl
	import fem_pkg::*;
#(
	parameter int PF_BYTES = `FEM_PF_BYTES,
	parameter int EE_BYTES = `FEM_EE_BYTES
)(
	input  wire logic  clk_i,
	input  wire logic  reset_n_i,
	input  fem_cmd_wr_s cmd_wr_i,
	input  wire logic  cmd_launch_i,
	input  fem_rd_req_s rd_req_i,
	output logic       rd_ready_o,
	output fem_rd_rsp_s rd_rsp_o,
	output logic       command_complete_flag_o,
	output logic       access_err_o,
	output logic       verify_err_o,
	output logic       irq_o
);
	// Derived sizes.
	localparam int PF_DW  = PF_BYTES / 4;
	localparam int EE_WD  = EE_BYTES / 2;
	localparam int PFI_W  = $clog2(PF_DW);
	localparam int EEI_W  = $clog2(EE_WD);
	localparam int NCCOB  = `FEM_CCOB_WORDS;
	localparam int TMR_W  = 16;

	// The layout fixes flash in whole sectors, EEPROM likewise.
	if (PF_BYTES % (4 * `FEM_PF_SECT_DW) != 0 || PF_BYTES > 32768 ||
		EE_BYTES % (2 * `FEM_EE_SECT_WD) != 0 || EE_BYTES > 32768 ||
		EE_BYTES < 8)
	begin : g_chk
		$error("fem_ctrl: unsupported array size");
	end

	// Whole block state, arrays included.
	typedef struct packed {
		logic [PF_DW-1:0][31:0]  pf_data;  // Flash double words.
		logic [PF_DW-1:0][6:0]   pf_chk;   // Their check bits.
		logic [EE_WD-1:0][15:0]  ee_data;  // EEPROM words.
		logic [EE_WD-1:0][5:0]   ee_chk;   // Their check bits.
		logic [NCCOB-1:0][15:0]  ccob;     // Command object.
		logic [2:0]              top;      // Last index loaded.
		fem_state_e              state;    // Sequencer state.
		fem_op_e                 op;       // Running operation.
		logic [PFI_W-1:0]        base;     // First unit index.
		logic [PFI_W-1:0]        cnt;      // Unit within operation.
		logic [PFI_W-1:0]        last;     // Last unit number.
		logic                    command_complete_flag;     // Command complete.
		logic                    acc_err;  // Refused command.
		logic                    ver_err;  // Verify mismatch.
		logic                    irq;      // Event pulse.
		fem_rd_rsp_s             rsp;      // Read answer.
	} fem_st_s;

	fem_st_s          st_ff;      // Registered state.
	fem_st_s          nxt_st;     // Next state.
	logic             tmr_start;  // Starts the pulse timer.
	logic [TMR_W-1:0] tmr_cyc;    // Pulse length in cycles.
	logic             tmr_done;   // Pulse time elapsed.
	logic [31:0]      pf_enc_d;   // Flash value to encode.
	logic [6:0]       pf_enc_c;   // Its check bits.
	logic [31:0]      pf_rd_d;    // Corrected flash read.
	logic             pf_sgl;     // Flash single fault.
	logic             pf_dbl;     // Flash double fault.
	logic [15:0]      ee_enc_d;   // EEPROM value to encode.
	logic [5:0]       ee_enc_c;   // Its check bits.
	logic [15:0]      ee_rd_d;    // Corrected EEPROM read.
	logic             ee_sgl;     // EEPROM single fault.
	logic             ee_dbl;     // EEPROM double fault.
	logic [PFI_W-1:0] pf_unit;    // Flash unit being worked.
	logic [EEI_W-1:0] ee_unit;    // EEPROM unit being worked.
	logic [PFI_W-1:0] pf_ridx;    // Flash read index.
	logic [EEI_W-1:0] ee_ridx;    // EEPROM read index.

	// Reads a command object word by index.
	function automatic logic [15:0] fem_word(
		input logic [NCCOB-1:0][15:0] c, input int unsigned i);
		fem_word = (i < NCCOB) ? c[i] : 16'hffff;
	endfunction

	// Picks a byte of a big-endian word, zero above it.
	function automatic logic [15:0] fem_byte(input logic [15:0] w,
		input logic lo);
		fem_byte = {8'h00, lo ? w[7:0] : w[15:8]};
	endfunction

	////////////////////////////////////////////////////////////////////
	// Work unit addresses and encode sources.

	assign pf_unit = st_ff.base + st_ff.cnt;
	assign ee_unit = st_ff.base[EEI_W-1:0] + st_ff.cnt[EEI_W-1:0];
	assign pf_ridx = rd_req_i.addr[PFI_W+1:2];
	assign ee_ridx = rd_req_i.addr[EEI_W:1];

	// Erase writes all ones, program takes the object's data words.
	always_comb
	begin
		int unsigned k;
		k = 32'(st_ff.cnt[1:0]);
		if (st_ff.op == OP_PF_ERASE)
			pf_enc_d = '1;
		else
			pf_enc_d = {fem_word(st_ff.ccob, 2 + 2 * k),
				fem_word(st_ff.ccob, 3 + 2 * k)};
		if (st_ff.op == OP_EE_ERASE)
			ee_enc_d = '1;
		else
			ee_enc_d = fem_word(st_ff.ccob, 2 + k);
	end

	////////////////////////////////////////////////////////////////////
	// Check bit generation and read correction.

	// Flash: seven check bits per 32-bit double word.
	fem_ecc #(.DW(32), .PW(7)) u_pf_ecc (
		.enc_data_i (pf_enc_d),
		.enc_chk_o  (pf_enc_c),
		.dec_data_i (st_ff.pf_data[pf_ridx]),
		.dec_chk_i  (st_ff.pf_chk[pf_ridx]),
		.dec_data_o (pf_rd_d),
		.dec_sgl_o  (pf_sgl),
		.dec_dbl_o  (pf_dbl)
	);

	// EEPROM: six check bits per 16-bit word.
	fem_ecc #(.DW(16), .PW(6)) u_ee_ecc (
		.enc_data_i (ee_enc_d),
		.enc_chk_o  (ee_enc_c),
		.dec_data_i (st_ff.ee_data[ee_ridx]),
		.dec_chk_i  (st_ff.ee_chk[ee_ridx]),
		.dec_data_o (ee_rd_d),
		.dec_sgl_o  (ee_sgl),
		.dec_dbl_o  (ee_dbl)
	);

	// Program and erase pulse timer.
	fem_optimer #(.W(TMR_W)) u_tmr (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.start_i   (tmr_start),
		.cycles_i  (tmr_cyc),
		.done_o    (tmr_done)
	);

	////////////////////////////////////////////////////////////////////
	// Read arbitration.

	// Flash stays readable during EEPROM work; EEPROM waits for idle.
	always_comb
	begin
		if (rd_req_i.ee)
			rd_ready_o = (st_ff.state == ST_IDLE);
		else
			rd_ready_o = (st_ff.state == ST_IDLE) ||
				(st_ff.op == OP_EE_PROG) || (st_ff.op == OP_EE_ERASE);
	end

	////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb
	begin
		logic [23:0] ga;
		logic [23:0] pfo;
		logic [23:0] eeo;
		logic [7:0]  code;
		logic [2:0]  nwd;
		logic        ok;
		nxt_st    = st_ff;
		tmr_start = 1'b0;
		tmr_cyc   = '0;
		code      = st_ff.ccob[`FEM_IDX_CMD][15:8];
		ga        = {st_ff.ccob[`FEM_IDX_CMD][7:0],
			st_ff.ccob[`FEM_IDX_ADDR]};
		pfo       = ga - `FEM_PF_BASE;
		eeo       = ga - `FEM_EE_BASE;
		nwd       = st_ff.top - 3'(`FEM_IDX_DATA0 - 1);
		ok        = 1'b0;
		nxt_st.irq       = 1'b0;
		nxt_st.rsp.valid = 1'b0;

		// Answer one cycle after the request is taken.
		if (rd_req_i.req && rd_ready_o)
		begin
			nxt_st.rsp.valid = 1'b1;
			if (rd_req_i.ee)
			begin
				nxt_st.rsp.data = rd_req_i.word ? ee_rd_d :
					fem_byte(ee_rd_d, rd_req_i.addr[0]);
				nxt_st.rsp.sgl  = ee_sgl;
				nxt_st.rsp.dbl  = ee_dbl;
			end
			else
			begin
				// Half-phrase fetch; its one bad bit is mended.
				nxt_st.rsp.data = rd_req_i.word ?
					(rd_req_i.addr[1] ? pf_rd_d[15:0] : pf_rd_d[31:16]) :
					fem_byte(rd_req_i.addr[1] ? pf_rd_d[15:0] :
					pf_rd_d[31:16], rd_req_i.addr[0]);
				nxt_st.rsp.sgl  = pf_sgl;
				nxt_st.rsp.dbl  = pf_dbl;
			end
			// A double fault is a flash error event.
			if (rd_req_i.ee ? ee_dbl : pf_dbl)
				nxt_st.irq = 1'b1;
		end

		// Object loads only while idle; other indices are dropped.
		if (cmd_wr_i.wr && st_ff.command_complete_flag && cmd_wr_i.idx < 3'(NCCOB))
		begin
			nxt_st.ccob[cmd_wr_i.idx] = cmd_wr_i.data;
			nxt_st.top                = cmd_wr_i.idx;
		end

		unique case (st_ff.state)
			// Decode and check a launched command.
			ST_IDLE:
				if (cmd_launch_i && st_ff.command_complete_flag)
				begin
					nxt_st.acc_err = 1'b0;
					nxt_st.ver_err = 1'b0;
					nxt_st.cnt     = '0;
					if (code == `FEM_CMD_PF_PROG &&
						pfo < 24'(PF_BYTES) && pfo[2:0] == 3'h0 &&
						st_ff.top == 3'(NCCOB - 1))
					begin
						ok          = 1'b1;
						nxt_st.op   = OP_PF_PROG;
						nxt_st.base = pfo[PFI_W+1:2];
						nxt_st.last = PFI_W'(`FEM_PF_PHRASE_DW - 1);
					end
					else if (code == `FEM_CMD_PF_ERASE &&
						pfo < 24'(PF_BYTES))
					begin
						ok          = 1'b1;
						nxt_st.op   = OP_PF_ERASE;
						nxt_st.base = {pfo[PFI_W+1:9], 7'h00};
						nxt_st.last = PFI_W'(`FEM_PF_SECT_DW - 1);
					end
					else if (code == `FEM_CMD_EE_PROG &&
						eeo < 24'(EE_BYTES) && !eeo[0] &&
						st_ff.top >= `FEM_IDX_DATA0 &&
						32'(eeo[EEI_W:1]) + 32'(nwd) <= EE_WD)
					begin
						ok          = 1'b1;
						nxt_st.op   = OP_EE_PROG;
						nxt_st.base = PFI_W'(eeo[EEI_W:1]);
						nxt_st.last = PFI_W'(nwd - 3'h1);
					end
					else if (code == `FEM_CMD_EE_ERASE &&
						eeo < 24'(EE_BYTES))
					begin
						ok          = 1'b1;
						nxt_st.op   = OP_EE_ERASE;
						nxt_st.base = PFI_W'({eeo[EEI_W:2], 1'b0});
						nxt_st.last = PFI_W'(`FEM_EE_SECT_WD - 1);
					end
					if (ok)
					begin
						nxt_st.command_complete_flag  = 1'b0;
						nxt_st.state = ST_WAIT;
						tmr_start    = 1'b1;
						tmr_cyc      = (nxt_st.op == OP_PF_ERASE ||
							nxt_st.op == OP_EE_ERASE) ?
							TMR_W'(`FEM_ERASE_CYC) : TMR_W'(`FEM_PROG_CYC);
					end
					else
					begin
						// Refused commands still complete and signal.
						nxt_st.acc_err = 1'b1;
						nxt_st.irq     = 1'b1;
					end
				end
			// Wait out the pulse time.
			ST_WAIT:
				if (tmr_done)
					nxt_st.state = ST_WRITE;
			// Store one unit per cycle with fresh check bits.
			ST_WRITE:
			begin
				unique case (st_ff.op)
					// Programming can only clear bits.
					OP_PF_PROG:
					begin
						nxt_st.pf_data[pf_unit] =
							st_ff.pf_data[pf_unit] & pf_enc_d;
						// Check bits come fresh from the new phrase, so a
						// clean program over erased cells decodes cleanly.
						nxt_st.pf_chk[pf_unit] = pf_enc_c;
					end
					OP_PF_ERASE:
					begin
						nxt_st.pf_data[pf_unit] = pf_enc_d;
						nxt_st.pf_chk[pf_unit]  = pf_enc_c;
					end
					OP_EE_PROG:
					begin
						nxt_st.ee_data[ee_unit] =
							st_ff.ee_data[ee_unit] & ee_enc_d;
						nxt_st.ee_chk[ee_unit] = ee_enc_c;
					end
					OP_EE_ERASE:
					begin
						nxt_st.ee_data[ee_unit] = ee_enc_d;
						nxt_st.ee_chk[ee_unit]  = ee_enc_c;
					end
					OP_NONE:
						nxt_st.state = ST_IDLE;
				endcase
				if (st_ff.cnt == st_ff.last)
				begin
					nxt_st.cnt   = '0;
					nxt_st.state = ST_VERIFY;
				end
				else
					nxt_st.cnt = st_ff.cnt + PFI_W'(1);
			end
			// Read back each unit and compare with intent.
			ST_VERIFY:
			begin
				if ((st_ff.op == OP_PF_PROG || st_ff.op == OP_PF_ERASE) &&
					{st_ff.pf_data[pf_unit], st_ff.pf_chk[pf_unit]} !=
					{pf_enc_d, pf_enc_c})
					nxt_st.ver_err = 1'b1;
				if ((st_ff.op == OP_EE_PROG || st_ff.op == OP_EE_ERASE) &&
					{st_ff.ee_data[ee_unit], st_ff.ee_chk[ee_unit]} !=
					{ee_enc_d, ee_enc_c})
					nxt_st.ver_err = 1'b1;
				if (st_ff.cnt == st_ff.last)
				begin
					nxt_st.state = ST_IDLE;
					nxt_st.op    = OP_NONE;
					nxt_st.command_complete_flag  = 1'b1;
					nxt_st.irq   = 1'b1;
				end
				else
					nxt_st.cnt = st_ff.cnt + PFI_W'(1);
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// State register.

	// Arrays are nonvolatile, so reset leaves them alone.
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			st_ff.ccob    <= '0;
			st_ff.top     <= '0;
			st_ff.state   <= ST_IDLE;
			st_ff.op      <= OP_NONE;
			st_ff.base    <= '0;
			st_ff.cnt     <= '0;
			st_ff.last    <= '0;
			st_ff.command_complete_flag    <= 1'b1;
			st_ff.acc_err <= 1'b0;
			st_ff.ver_err <= 1'b0;
			st_ff.irq     <= 1'b0;
			st_ff.rsp     <= '0;
		end
		else
			st_ff <= nxt_st;
	end

	// Outputs other than rd_ready_o come from the state register.
	assign rd_rsp_o                = st_ff.rsp;
	assign command_complete_flag_o = st_ff.command_complete_flag;
	assign access_err_o            = st_ff.acc_err;
	assign verify_err_o            = st_ff.ver_err;
	assign irq_o                   = st_ff.irq;
endmodule // fem_ctrl

// File: fem_ctrl_monitor.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module fem_ctrl_monitor
	import fem_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  reset_n_i,
	input  fem_cmd_wr_s cmd_wr_i,
	input  wire logic  cmd_launch_i,
	input  fem_rd_req_s rd_req_i,
	input  wire logic  rd_ready_o,
	input  fem_rd_rsp_s rd_rsp_o,
	input  wire logic  command_complete_flag_o,
	input  wire logic  access_err_o,
	input  wire logic  verify_err_o,
	input  wire logic  irq_o
);
	// Every check runs on the bus clock and rests during reset.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	////////////////////////////////////////////////////////////////////////
	a_read_latency: assert property (
		rd_req_i.req && rd_ready_o |=> rd_rsp_o.valid)
		else $error("read answer missing one cycle later");
	a_no_stray_valid: assert property (
		!(rd_req_i.req && rd_ready_o) |=> !rd_rsp_o.valid)
		else $error("read answer without a taken request");
	a_byte_upper_zero: assert property (
		rd_rsp_o.valid && !$past(rd_req_i.word) |->
		rd_rsp_o.data[15:8] == 8'h00)
		else $error("byte read upper half not zero");
	a_eeprom_blocked: assert property (
		!command_complete_flag_o && rd_req_i.ee |-> !rd_ready_o)
		else $error("data array read taken while busy");
	a_idle_ready: assert property (
		command_complete_flag_o |-> rd_ready_o)
		else $error("reads stalled while idle");
	a_launch_taken: assert property (
		cmd_launch_i && command_complete_flag_o |=>
		!command_complete_flag_o || (access_err_o && irq_o))
		else $error("launch neither started nor refused");
	a_busy_no_refuse: assert property (
		!command_complete_flag_o |=> !$rose(access_err_o))
		else $error("launch judged while a command runs");
	a_refuse_irq: assert property (
		$rose(access_err_o) |-> irq_o && command_complete_flag_o)
		else $error("refusal without interrupt");
	a_done_irq: assert property (
		$rose(command_complete_flag_o) |-> irq_o)
		else $error("completion without interrupt");
	a_double_irq: assert property (
		rd_rsp_o.valid && rd_rsp_o.dbl |-> irq_o)
		else $error("double fault without interrupt");
	a_busy_bounded: assert property (
		$fell(command_complete_flag_o) |->
		##[20:400] command_complete_flag_o)
		else $error("command ran out of its time bound");
endmodule // fem_ctrl_monitor

bind fem_ctrl fem_ctrl_monitor u_mon (.clk_i, .reset_n_i, .cmd_wr_i,
	.cmd_launch_i, .rd_req_i, .rd_ready_o, .rd_rsp_o,
	.command_complete_flag_o, .access_err_o, .verify_err_o, .irq_o);

// File: fem_cpu_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module fem_cpu_model
	import fem_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  flag_i,
	input  wire logic  ready_i,
	input  fem_rd_rsp_s rsp_i,
	output fem_cmd_wr_s cmd_wr_o,
	output logic       launch_o,
	output fem_rd_req_s rd_req_o
);
	// Idle bus at time zero, with a junk address on the read lines.
	initial
	begin
		cmd_wr_o = '0;
		launch_o = 1'b0;
		rd_req_o = '{1'b0, 1'b0, 1'b0, 15'h5555};
	end
	// Loads one object word, only once the controller is idle.
	task automatic put(input logic [2:0] i, input logic [15:0] d);
		while (!flag_i) @(negedge clk_i);
		@(posedge clk_i);
		cmd_wr_o <= '{1'b1, i, d};
	endtask
	// Drops the write strobe, scrambles its lines and pulses launch.
	task automatic go();
		@(posedge clk_i);
		cmd_wr_o <= '{1'b0, ~cmd_wr_o.idx, ~cmd_wr_o.data};
		launch_o <= 1'b1;
		@(posedge clk_i);
		launch_o <= 1'b0;
	endtask
	// Holds a read until ready, then returns the answer data.
	task automatic rd(input logic ee, input logic w, input logic [14:0] a,
		output logic [15:0] q);
		@(posedge clk_i);
		rd_req_o <= '{1'b1, ee, w, a};
		@(negedge clk_i);
		while (!ready_i) @(negedge clk_i);
		@(posedge clk_i);
		rd_req_o <= '{1'b0, ~ee, ~w, ~a};
		@(negedge clk_i);
		q = rsp_i.valid ? rsp_i.data : 16'hxxxx;
	endtask
	// Offers a word read for one cycle and reports whether it was taken.
	task automatic probe(input logic ee, output logic r);
		@(posedge clk_i);
		rd_req_o <= '{1'b1, ee, 1'b1, 15'h0};
		@(negedge clk_i);
		r = ready_i;
		@(posedge clk_i);
		rd_req_o <= '{1'b0, ~ee, 1'b0, 15'h7fff};
	endtask
endmodule // fem_cpu_model

// File: test_flash_eeprom_memory_controller.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end
////////////////////////////////////////////////////////////////////////////
module test_flash_eeprom_memory_controller;
	import fem_pkg::*;
	logic        clk = 1'b0;     // Bus clock.
	logic        reset_n = 1'b0; // Active low reset.
	fem_cmd_wr_s cmd_wr;         // Object writes.
	logic        launch;         // Command start.
	fem_rd_req_s rd_req;         // Read request.
	fem_rd_rsp_s rsp;            // Read answer.
	logic        ready, flag, aerr, verr, irq;
	int          bad_count = 0;  // Mismatches.
	int          checks = 0;     // Comparisons.
	int          cyc = 0;        // Cycles for the hang guard.
	logic        r;
	always #5 clk = ~clk;
	fem_ctrl #(.PF_BYTES(1024), .EE_BYTES(128)) dut (.clk_i(clk),
		.reset_n_i(reset_n), .cmd_wr_i(cmd_wr), .cmd_launch_i(launch),
		.rd_req_i(rd_req), .rd_ready_o(ready), .rd_rsp_o(rsp),
		.command_complete_flag_o(flag), .access_err_o(aerr),
		.verify_err_o(verr), .irq_o(irq));
	fem_cpu_model u_cpu (.clk_i(clk), .flag_i(flag), .ready_i(ready),
		.rsp_i(rsp), .cmd_wr_o(cmd_wr), .launch_o(launch),
		.rd_req_o(rd_req));
	////////////////////////////////////////////////////////////////////////
	// Prints counts and verdict, then stops.
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Cuts a hang short well beyond the longest expected run.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			wrap_up();
		end
	end
	// Writes object words 0 to top and launches.
	task automatic cmd(input logic [7:0] c, input logic [23:0] ga,
		input logic [0:3][15:0] d, input int top);
		u_cpu.put(3'h0, {c, ga[23:16]});
		u_cpu.put(3'h1, ga[15:0]);
		for (int i = 2; i <= top; i++) u_cpu.put(3'(i), d[i-2]);
		u_cpu.go();
		@(negedge clk);
	endtask
	// Waits for completion and judges flag, interrupt and verify result.
	task automatic done(input logic ve);
		int n;
		n = 0;
		`CHK(flag, 1'b0)
		`CHK(aerr, 1'b0)
		while (!flag && n < 600)
		begin
			@(negedge clk);
			n++;
		end
		`CHK(flag, 1'b1)
		`CHK(irq, 1'b1)
		`CHK(verr, ve)
	endtask
	// Reads and compares one answer.
	task automatic rdchk(input logic ee, input logic w, input logic [14:0] a,
		input logic [15:0] e);
		logic [15:0] q;
		u_cpu.rd(ee, w, a, q);
		`CHK(q, e)
		`CHK({rsp.sgl, rsp.dbl}, 2'b00)
	endtask
	////////////////////////////////////////////////////////////////////////
	// Data array: erase with read stalls, burst program, reprogram.
	task automatic t_eeprom();
		logic [0:3][15:0] d;
		d = {16'h5678, 16'h9abc, 16'hdef0, 16'h0f1e};
		cmd(8'h12, 24'h10_0000, '0, 1);
		u_cpu.probe(1'b1, r);
		`CHK(r, 1'b0)
		u_cpu.probe(1'b0, r);
		`CHK(r, 1'b1)
		done(1'b0);
		cmd(8'h12, 24'h10_0006, '0, 1);
		done(1'b0);
		rdchk(1'b1, 1'b1, 15'h0002, 16'hffff);
		rdchk(1'b1, 1'b0, 15'h0007, 16'h00ff);
		cmd(8'h11, 24'h10_0000, d, 5);
		done(1'b0);
		for (int i = 0; i < 4; i++) rdchk(1'b1, 1'b1, 15'(2*i), d[i]);
		cmd(8'h11, 24'h10_0000, {16'h1234, 48'h0}, 2);
		done(1'b1);
	endtask
	// Program array: erase, phrase program, reads of both halves.
	task automatic t_flash();
		logic [0:3][15:0] d;
		d = {16'h1122, 16'h3344, 16'h5566, 16'h7788};
		cmd(8'h0a, 24'hff_8010, '0, 1);
		u_cpu.probe(1'b1, r);
		`CHK(r, 1'b0)
		done(1'b0);
		rdchk(1'b0, 1'b1, 15'h01fe, 16'hffff);
		cmd(8'h06, 24'hff_8000, d, 5);
		done(1'b0);
		for (int i = 0; i < 4; i++) rdchk(1'b0, 1'b1, 15'(2*i), d[i]);
		rdchk(1'b0, 1'b1, 15'h0008, 16'hffff);
	endtask
	// Refused launches: each must flag and interrupt at once.
	task automatic t_refuse();
		logic [7:0]  c [5] = '{8'h7f, 8'h11, 8'h06, 8'h06, 8'h12};
		logic [23:0] a [5] = '{24'h10_0000, 24'h10_0001, 24'hff_8002,
			24'hff_8000, 24'h10_0080};
		int          t [5] = '{1, 2, 5, 3, 1};
		for (int i = 0; i < 5; i++)
		begin
			cmd(c[i], a[i], '0, t[i]);
			`CHK(aerr, 1'b1)
			`CHK(irq, 1'b1)
			`CHK(flag, 1'b1)
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		`CHK({flag, aerr, verr, irq, ready}, 5'h11)
		// Flash first, so the flash read offered during EEPROM work
		// meets cells that have been written.
		t_flash();
		t_eeprom();
		t_refuse();
		wrap_up();
	end
endmodule // test_flash_eeprom_memory_controller
